/* File: rtl/fsp_map.svh */
// Summary of operation
// R01: bits 7:6 of spin-up config always read as zero.
// R02: fast bit clear: spin-up uses programmed duty and time fields.
// R03: fast bit set: full duty until interval ends or tach setpoint reached.
// R04: fast bit set: duty field ignored, spin-up always full duty.
// R05: time field zero skips spin-up whatever the fast bit.
// R06: duty code 0 skips unless fast; 1 half; 2 three quarters; 3 full.
// R07: time codes 1..7 give 0.05, 0.1, 0.2, 0.4, 0.8, 1.6, 3.2 seconds.
// R08: software selects tach input mode before using fast spin-up.
// R09: pwm value register read-only while programming enable is clear.
// R10: pwm value high-resolution bits are zero after reset.
// R11: pwm value register reads zero during spin-up.
// R12: programming enabled: written value drives output; else lookup value shown.
// R13: after spin-up, output follows lookup value or written value.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
// register indices; byte address is four times the index
`define FSP_IDX_FAN_CONFIG    8'h4a
`define FSP_IDX_FAST_TACH_TERMINATED_SPIN_CONFIG 8'h4b
`define FSP_IDX_PWM_VALUE     8'h4c
`define FSP_ADDR_FAN_CONFIG   12'h128
`define FSP_ADDR_FAST_TACH_TERMINATED_SPIN_CFG   12'h12c
`define FSP_ADDR_PWM_VALUE    12'h130
// field positions
`define FSP_BIT_PROG_EN       5
`define FSP_BIT_FAST          5
`define FSP_DUTY_MSB          4
`define FSP_DUTY_LSB          3
`define FSP_TIME_MSB          2
`define FSP_TIME_LSB          0
// reset values
`define FSP_RST_FAN_CONFIG    6'h20
`define FSP_RST_FAST_TACH_TERMINATED_SPIN_CFG    6'h3f
`define FSP_RST_PWM_VALUE     8'h00
// duty levels
`define FSP_DUTY_FULL         8'hff
`define FSP_DUTY_HALF         8'h80
`define FSP_DUTY_3Q           8'hc0
// timing: shortest interval and clock rate
`define FSP_BASE_TIME_US      32'hc350
`define FSP_CLK_MHZ           32'hfa
`define FSP_BASE_CYCLES       (`FSP_BASE_TIME_US * `FSP_CLK_MHZ)
`endif

/* File: rtl/fsp_pkg.sv */
package fsp_pkg;
  typedef enum logic {FSP_IDLE, FSP_SPIN} fsp_state_t;
endpackage

/* File: rtl/fsp_top.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "fsp_map.svh"
module fsp_top #(
  parameter logic [31:0] BASE_CYCLES = `FSP_BASE_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // fan side
  input  wire logic        spin_request,
  input  wire logic        tach_setpoint_reached,
  input  wire logic [7:0]  lut_pwm_value,
  output logic [7:0]       pwm_duty,
  output logic             spin_active
);

  logic [5:0]  fan_config;
  logic [5:0]  fast_tach_terminated_spin_config;
  logic [7:0]  pwm_duty_value;
  logic        tach_meta;
  logic        tach_sync;
  logic [31:0] spin_count;
  logic [31:0] next_interval;
  logic [7:0]  next_spin_duty;
  logic [7:0]  spin_duty;
  logic [7:0]  next_pwm_duty;
  logic        skip_spin;
  logic        spin_done;
  logic        setup_phase;
  logic        wr_access;
  logic        addr_hit;
  logic        lane0;
  logic [2:0]  time_sel_q;
  fsp_pkg::fsp_state_t state;

  wire logic       prog_en = fan_config[`FSP_BIT_PROG_EN];
  wire logic       fast    = fast_tach_terminated_spin_config[`FSP_BIT_FAST];
  wire logic [1:0] duty_sel =
    fast_tach_terminated_spin_config[`FSP_DUTY_MSB:`FSP_DUTY_LSB];
  wire logic [2:0] time_sel =
    fast_tach_terminated_spin_config[`FSP_TIME_MSB:`FSP_TIME_LSB];

  // apb handshake: zero wait states, read data registered in the setup cycle, writes taken in the access cycle
  assign pready      = penable;
  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite;
  assign lane0       = pstrb[0];
  assign addr_hit    = (paddr == `FSP_ADDR_FAN_CONFIG) ||
                       (paddr == `FSP_ADDR_FAST_TACH_TERMINATED_SPIN_CFG) ||
                       (paddr == `FSP_ADDR_PWM_VALUE);

  // tach level comes from a pin
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tach_meta <= 1'b0;
      tach_sync <= 1'b0;
    end
    else
    begin
      tach_meta <= tach_setpoint_reached;
      tach_sync <= tach_meta;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      fan_config    <= `FSP_RST_FAN_CONFIG;
      fast_tach_terminated_spin_config <= `FSP_RST_FAST_TACH_TERMINATED_SPIN_CFG;
    end
    else if (wr_access && lane0)
    begin
      if (paddr == `FSP_ADDR_FAN_CONFIG)
        fan_config <= pwdata[5:0];
      if (paddr == `FSP_ADDR_FAST_TACH_TERMINATED_SPIN_CFG)
        fast_tach_terminated_spin_config <= pwdata[5:0];
    end
  end

  // R10 reset to zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pwm_duty_value <= `FSP_RST_PWM_VALUE;
    // R09 writes gated
    else if (wr_access && lane0 && prog_en &&
             paddr == `FSP_ADDR_PWM_VALUE)
      pwm_duty_value <= pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      pslverr <= !addr_hit;
      prdata  <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          `FSP_ADDR_FAN_CONFIG:
            prdata <= {26'h0, fan_config};
          // R01 upper bits zero
          `FSP_ADDR_FAST_TACH_TERMINATED_SPIN_CFG:
            prdata <= {26'h0, fast_tach_terminated_spin_config};
          `FSP_ADDR_PWM_VALUE:
          begin
            // R11 zero while spinning
            if (state == fsp_pkg::FSP_SPIN)
              prdata <= 32'h0000_0000;
            // R12 direct or lookup value
            else if (prog_en)
              prdata <= {24'h0, pwm_duty_value};
            else
              prdata <= {24'h0, lut_pwm_value};
          end
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // R05 zero time skips
  // R06 duty code zero skips unless fast
  assign skip_spin = (time_sel == 3'h0) ||
                     (duty_sel == 2'h0 && !fast);

  // R07 interval doubles per code
  always_comb
  begin
    next_interval = 32'h0000_0000;
    if (time_sel != 3'h0)
      next_interval = (BASE_CYCLES << (time_sel - 3'h1)) - 32'h1;
  end

  // R04 fast overrides duty field
  // R06 duty decode
  always_comb
  begin
    case (duty_sel)
      2'h1:    next_spin_duty = `FSP_DUTY_HALF;
      2'h2:    next_spin_duty = `FSP_DUTY_3Q;
      default: next_spin_duty = `FSP_DUTY_FULL;
    endcase
    if (fast)
      next_spin_duty = `FSP_DUTY_FULL;
  end

  // R03 first of timeout or tach
  assign spin_done = (spin_count == 32'h0000_0000) ||
                     (fast && tach_sync);

  // R02 programmed duty and time
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state      <= fsp_pkg::FSP_IDLE;
      spin_count <= 32'h0000_0000;
      spin_duty  <= 8'h00;
    end
    else
    begin
      case (state)
        fsp_pkg::FSP_IDLE:
        begin
          if (spin_request && !skip_spin)
          begin
            state      <= fsp_pkg::FSP_SPIN;
            spin_count <= next_interval;
            spin_duty  <= next_spin_duty;
          end
        end
        fsp_pkg::FSP_SPIN:
        begin
          if (spin_done)
            state <= fsp_pkg::FSP_IDLE;
          else
            spin_count <= spin_count - 32'h1;
        end
        default:
          state <= fsp_pkg::FSP_IDLE;
      endcase
    end
  end

  // R13 hand over after spin-up
  always_comb
  begin
    if (state == fsp_pkg::FSP_SPIN)
      next_pwm_duty = spin_duty;
    else if (prog_en)
      next_pwm_duty = pwm_duty_value;
    else
      next_pwm_duty = lut_pwm_value;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pwm_duty    <= 8'h00;
      spin_active <= 1'b0;
    end
    else
    begin
      pwm_duty    <= next_pwm_duty;
      spin_active <= (state == fsp_pkg::FSP_SPIN);
    end
  end

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
    (setup_phase && !pwrite && paddr == `FSP_ADDR_FAST_TACH_TERMINATED_SPIN_CFG)
      |=> prdata[31:6] == 26'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R01
    else $error("spin-up config upper bits not zero");

  property p_start_duty;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && spin_request && !skip_spin && !fast
      && duty_sel == 2'h1) |=> ##1 pwm_duty == `FSP_DUTY_HALF;
  endproperty
  a_start_duty: assert property (p_start_duty) // R02
    else $error("half duty code not applied");

  property p_tach_end;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_SPIN && fast && tach_sync)
      |=> state == fsp_pkg::FSP_IDLE;
  endproperty
  a_tach_end: assert property (p_tach_end) // R03
    else $error("tach did not end fast spin-up");

  property p_fast_full;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && spin_request && !skip_spin && fast)
      |=> ##1 pwm_duty == `FSP_DUTY_FULL;
  endproperty
  a_fast_full: assert property (p_fast_full) // R04
    else $error("fast spin-up not at full duty");

  property p_skip_time;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && time_sel == 3'h0)
      |=> state == fsp_pkg::FSP_IDLE;
  endproperty
  a_skip_time: assert property (p_skip_time) // R05
    else $error("spin-up started with zero time");

  property p_interval;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && spin_request && !skip_spin)
      |=> spin_count == (BASE_CYCLES << (time_sel_q - 3'h1)) - 32'h1;
  endproperty
  always_ff @(posedge clk)
  begin
    time_sel_q <= time_sel;
  end
  a_interval: assert property (p_interval) // R07
    else $error("spin interval mismatch");

  property p_ro_value;
    @(posedge clk) disable iff (!rst_b)
    (!prog_en && !(wr_access && paddr == `FSP_ADDR_FAN_CONFIG))
      |=> $stable(pwm_duty_value);
  endproperty
  a_ro_value: assert property (p_ro_value) // R09
    else $error("pwm value changed while read-only");

  property p_spin_read_zero;
    @(posedge clk) disable iff (!rst_b)
    (setup_phase && !pwrite && paddr == `FSP_ADDR_PWM_VALUE
      && state == fsp_pkg::FSP_SPIN) |=> prdata == 32'h0;
  endproperty
  a_spin_read_zero: assert property (p_spin_read_zero) // R11
    else $error("pwm value nonzero during spin-up");

  property p_handover;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && !prog_en)
      |=> pwm_duty == $past(lut_pwm_value);
  endproperty
  a_handover: assert property (p_handover) // R13
    else $error("output not following lookup value");

  property p_three_quarter;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && spin_request && !skip_spin && !fast
      && duty_sel == 2'h2) |=> ##1 pwm_duty == `FSP_DUTY_3Q;
  endproperty
  a_three_quarter: assert property (p_three_quarter) // R06
    else $error("three quarter duty code not applied");

  property p_skip_duty;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && duty_sel == 2'h0 && !fast)
      |=> state == fsp_pkg::FSP_IDLE;
  endproperty
  a_skip_duty: assert property (p_skip_duty) // R06
    else $error("spin-up started with zero duty code");

  property p_time_end;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_SPIN && spin_count == 32'h0000_0000)
      |=> state == fsp_pkg::FSP_IDLE;
  endproperty
  a_time_end: assert property (p_time_end) // R03
    else $error("spin-up outlived its interval");

  property p_reset_value;
    @(posedge clk)
    !rst_b |=> pwm_duty_value == `FSP_RST_PWM_VALUE;
  endproperty
  a_reset_value: assert property (p_reset_value) // R10
    else $error("pwm value not cleared by reset");

  property p_direct_value;
    @(posedge clk) disable iff (!rst_b)
    (state == fsp_pkg::FSP_IDLE && prog_en)
      |=> pwm_duty == $past(pwm_duty_value);
  endproperty
  a_direct_value: assert property (p_direct_value) // R12
    else $error("output not following written value");

endmodule // fsp_top

/* File: test/fsp_fan_model.sv */
`timescale 1ns/10ps
module fsp_fan_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // drive from the block, and slow setpoint select from the test
  input  wire logic [7:0] pwm_duty,
  input  wire logic       slow,
  // tach comparator
  output logic            tach_setpoint_reached
);
  int speed;
  // speed builds only at full drive and coasts down otherwise
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      speed <= 0;
    else if (pwm_duty == 8'hff)
      speed <= speed + 1;
    else if (speed > 0)
      speed <= speed - 1;
  end
  assign tach_setpoint_reached = speed >= (slow ? 1000 : 20);
endmodule // fsp_fan_model

/* File: test/fsp_top_tb.sv */
`timescale 1ns/10ps
module fsp_top_tb;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, tach, spin_active;
  logic        spin_request = 0, slow = 0;
  logic [7:0]  lut = 8'h3c, post = 8'h55, pwm_duty;
  logic [7:0]  dv [1:3] = '{8'h80, 8'hc0, 8'hff};
  int          num_errors = 0, checks = 0, act_cnt = 0, i;

  always #2 clk = ~clk;
  always @(posedge clk)
    if (spin_active)
      act_cnt <= act_cnt + 1;

  fsp_top #(.BASE_CYCLES(32'h4)) u_fsp_top (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .spin_request(spin_request), .tach_setpoint_reached(tach),
    .lut_pwm_value(lut), .pwm_duty(pwm_duty), .spin_active(spin_active));

  fsp_fan_model u_fsp_fan_model (.clk(clk), .rst_b(rst_b),
    .pwm_duty(pwm_duty), .slow(slow), .tach_setpoint_reached(tach));

  task summarize;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    num_errors++;
    $display("Error at %0t: wait timed out", $time);
    summarize();
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      hang();
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 0, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask

  // hi of zero means the request must be refused
  task spin(input logic [7:0] cfg, input logic [7:0] duty, input int lo,
            input int hi);
    int n;
    apb(12'h12c, 1, {24'h0, cfg});
    act_cnt = 0;
    spin_request <= 1;
    @(posedge clk);
    spin_request <= 0;
    @(posedge clk);
    #1;
    chk(32'(spin_active), 32'(hi != 0));
    if (hi != 0)
    begin
      chk(32'(pwm_duty), 32'(duty));
      rdc(12'h130, 32'h0);
      n = 0;
      while (spin_active === 1'b1 && n < 2000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 2000)
        hang();
      chk(32'(act_cnt >= lo && act_cnt <= hi), 32'h1);
      chk(32'(pwm_duty), 32'(post));
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    rdc(12'h12c, 32'h3f);
    rdc(12'h128, 32'h20);
    rdc(12'h130, 32'h0);
    apb(12'h12c, 1, 32'hff);
    rdc(12'h12c, 32'h3f);
    apb(12'h134, 0, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    apb(12'h128, 1, 32'h0);
    apb(12'h130, 1, 32'h55);
    rdc(12'h130, 32'h3c);
    chk(32'(pwm_duty), 32'h3c);
    apb(12'h128, 1, 32'h20);
    rdc(12'h130, 32'h0);
    apb(12'h130, 1, 32'h55);
    rdc(12'h130, 32'h55);
    chk(32'(pwm_duty), 32'h55);
    $display("test program enable done");
    for (i = 1; i < 8; i++)
      spin({3'b000, 2'((i - 1) % 3 + 1), 3'(i)}, dv[(i - 1) % 3 + 1],
           4 << (i - 1), 4 << (i - 1));
    spin(8'h38, 8'h00, 0, 0);
    spin(8'h01, 8'h00, 0, 0);
    $display("test normal spin done");
    // software has already put the tach pin in tach mode
    spin(8'h2f, 8'hff, 15, 40);
    slow = 1;
    spin(8'h2a, 8'hff, 8, 8);
    spin(8'h21, 8'hff, 4, 4);
    $display("test fast spin done");
    apb(12'h128, 1, 32'h0);
    lut <= 8'h9a;
    post = 8'h9a;
    spin(8'h09, 8'h80, 4, 4);
    $display("test lookup handover done");
    // mid-run reset must clear the written value again
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    rdc(12'h130, 32'h0);
    chk(32'(pwm_duty), 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule // fsp_top_tb
